//--- mtseq_pkg.sv
package mtseq_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_CFG = 4'h1;
	localparam logic [3:0] ADDR_COUNTS = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
	localparam logic [3:0] ADDR_OUTBUF = 4'h6;
	localparam logic [3:0] ADDR_STORED = 4'h7;

	// ----------------------------------------
	// commands written to the command register
	// ----------------------------------------
	localparam logic [2:0] CMD_CONFIGURE = 3'h1;
	localparam logic [2:0] CMD_MEASURE = 3'h2;
	localparam logic [2:0] CMD_READ = 3'h3;
	localparam logic [2:0] CMD_INITIATE = 3'h4;
	localparam logic [2:0] CMD_FETCH = 3'h5;
	localparam logic [2:0] CMD_BUS_TRIG = 3'h6;

	// ----------------------------------------
	// settings and presets
	// ----------------------------------------
	localparam logic [1:0] BW_3HZ = 2'h0;
	localparam logic [1:0] BW_20HZ = 2'h1;
	localparam logic [1:0] BW_200HZ = 2'h2;
	localparam logic [1:0] SRC_IMMEDIATE = 2'h0;
	localparam logic [1:0] SRC_BUS = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL = 2'h2;
	localparam logic [2:0] PLC_0P02 = 3'h0;
	localparam logic [2:0] PLC_0P2 = 3'h1;
	localparam logic [2:0] PLC_1 = 3'h2;
	localparam logic [2:0] PLC_10 = 3'h3;
	localparam logic [2:0] PLC_100 = 3'h4;
	localparam logic [3:0] FN_FREQUENCY = 4'h7;
	localparam logic [3:0] FN_PERIOD = 4'h8;
	localparam logic [9:0] COUNT_ONE = 10'h001;
	localparam logic [19:0] MEM_DEPTH = 20'h00200;
	localparam int MEM_AW = 9;
	localparam int RDG_W = 24;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CFG_FUNC_LSB = 0;
	localparam int CFG_PLC_LSB = 4;
	localparam int CFG_BW_LSB = 8;
	localparam int CFG_SRC_LSB = 10;
	localparam int CFG_ZERO_BIT = 12;
	localparam int CFG_IMP_BIT = 13;
	localparam int CFG_DLY_BIT = 14;
	localparam int CFG_MATH_BIT = 15;
	localparam int CNT_SAMP_LSB = 0;
	localparam int CNT_TRIG_LSB = 16;

	// irq bits: done, memory error, output full
	localparam int IRQ_DONE = 0;
	localparam int IRQ_MEMERR = 1;
	localparam int IRQ_FULL = 2;

	typedef enum logic [1:0] {
		MTSEQ_IDLE = 2'b00,
		MTSEQ_WAIT = 2'b01,
		MTSEQ_MEAS = 2'b11,
		MTSEQ_FETCH = 2'b10
	} mtseq_state_t;
endpackage

//--- mtseq_mem.sv
`timescale 1ns/100ps
// reading store, registered read data
module mtseq_mem (
	// clock
	input wire logic mclk,
	// write side
	input wire logic wr_en,
	input wire logic [mtseq_pkg::MEM_AW-1:0] wr_addr,
	input wire logic [mtseq_pkg::RDG_W-1:0] wr_data,
	// read side
	input wire logic [mtseq_pkg::MEM_AW-1:0] rd_addr,
	output logic [mtseq_pkg::RDG_W-1:0] rd_data
);
	logic [mtseq_pkg::RDG_W-1:0] store [0:(1<<mtseq_pkg::MEM_AW)-1];

	// ----------------------------------------
	// single port write, registered read
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
		rd_data <= store[rd_addr];
	end
endmodule

//--- mtseq_trig.sv
`timescale 1ns/100ps
// trigger select: edge detector for external pulse, bus trigger passed through one register stage
module mtseq_trig (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// trigger inputs
	input wire logic [1:0] source,
	input wire logic ext_trig,
	input wire logic bus_trig,
	// trigger out
	output logic fire
);
	typedef struct packed {
		logic ext_q;
		logic fire;
	} mtseq_trig_s_t;
	mtseq_trig_s_t s, next_s;

	// ----------------------------------------
	// select trigger by source
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.ext_q = ext_trig;
		case (source)
			mtseq_pkg::SRC_IMMEDIATE: next_s.fire = 1'b1;
			mtseq_pkg::SRC_BUS: next_s.fire = bus_trig;
			mtseq_pkg::SRC_EXTERNAL: next_s.fire = ext_trig && !s.ext_q;
			default: next_s.fire = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign fire = s.fire;
endmodule

//--- mtseq_top.sv
`timescale 1ns/100ps
// Functional notes
// [R1] presets set ac filter to 20 Hz
// [R2] autozero off below one plc, else on
// [R3] presets disable auto input impedance
// [R4] presets sample and trigger counts to one
// [R5] presets auto delay, immediate source, math off
// [R6] measure equals configure then read
// [R7] measure fixes all but function, range, resolution
// [R8] configure presets only, trigger stays idle
// [R9] frequency and period use one range
// [R10] resolution in units, range with resolution
// [R11] read arms, readings go to output
// [R12] full output halts measuring until drained
// [R13] initiate stores up to 512 readings
// [R14] fetch moves stored readings to output
// [R15] counts product above 512 gives memory error
// [R16] busy after initiate, bus trigger still taken
// [R17] external pulse takes one reading each; the code takes sample count readings per pulse
// [R18] host reads each response before next query
// [R19] memory error leaves trigger idle
module mtseq_top (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// measurement front end
	input wire logic ext_trig,
	output logic meas_start,
	input wire logic meas_done,
	input wire logic [mtseq_pkg::RDG_W-1:0] meas_data,
	// output buffer stream
	output logic out_valid,
	output logic [mtseq_pkg::RDG_W-1:0] out_data,
	input wire logic out_ready,
	// status
	output logic busy,
	output logic irq
);
	typedef struct packed {
		mtseq_pkg::mtseq_state_t state;
		logic to_mem;
		logic [3:0] func;
		logic [2:0] plc;
		logic [1:0] bw;
		logic [1:0] src;
		logic zero;
		logic imp_auto;
		logic dly_auto;
		logic math;
		logic [9:0] samples;
		logic [9:0] trigs;
		logic [9:0] samp_left;
		logic [9:0] trig_left;
		logic pending;
		logic [mtseq_pkg::MEM_AW:0] wr_ptr;
		logic [mtseq_pkg::MEM_AW:0] rd_ptr;
		logic fetch_rd;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic meas_start;
		logic out_valid;
		logic [mtseq_pkg::RDG_W-1:0] out_data;
		logic [31:0] rdata;
		logic irq;
		logic busy;
	} mtseq_s_t;
	mtseq_s_t s, next_s;

	logic fire;
	logic bus_trig;
	logic mem_wr;
	logic [mtseq_pkg::RDG_W-1:0] mem_q;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// autozero on when integration at least one plc
	function automatic logic zero_for(input logic [2:0] plc);
		return plc >= mtseq_pkg::PLC_1; // R2
	endfunction

	function automatic logic [9:0] cnt_field(input logic [31:0] v,
		input int lsb);
		return v[lsb +: 10];
	endfunction

	// frequency and period share one fixed input range
	function automatic logic single_range(input logic [3:0] func);
		return func == mtseq_pkg::FN_FREQUENCY ||
			func == mtseq_pkg::FN_PERIOD; // R9
	endfunction

	assign bus_trig = wr && addr == mtseq_pkg::ADDR_CMD &&
		wdata[2:0] == mtseq_pkg::CMD_BUS_TRIG;
	assign mem_wr = s.state == mtseq_pkg::MTSEQ_MEAS && meas_done &&
		s.to_mem;

	mtseq_trig u_trig (
		.mclk(mclk),
		.rst_n(rst_n),
		.source(s.src),
		.ext_trig(ext_trig),
		.bus_trig(bus_trig),
		.fire(fire)
	);

	mtseq_mem u_mem (
		.mclk(mclk),
		.wr_en(mem_wr),
		.wr_addr(s.wr_ptr[mtseq_pkg::MEM_AW-1:0]),
		.wr_data(meas_data),
		.rd_addr(s.rd_ptr[mtseq_pkg::MEM_AW-1:0]),
		.rd_data(mem_q)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic cmd;
		logic [19:0] total;
		logic out_free;
		cmd = wr && addr == mtseq_pkg::ADDR_CMD;
		total = 20'(s.samples) * 20'(s.trigs);
		out_free = !s.out_valid || out_ready;
		next_s = s;
		next_s.meas_start = 1'b0;
		next_s.fetch_rd = 1'b0;
		if (s.out_valid && out_ready) begin
			next_s.out_valid = 1'b0;
		end
		// settings writes only while idle, refused when busy
		if (wr && s.state == mtseq_pkg::MTSEQ_IDLE) begin // R7 R16
			if (addr == mtseq_pkg::ADDR_CFG) begin
				next_s.func = wdata[mtseq_pkg::CFG_FUNC_LSB +: 4];
				next_s.plc = wdata[mtseq_pkg::CFG_PLC_LSB +: 3];
				next_s.bw = wdata[mtseq_pkg::CFG_BW_LSB +: 2];
				next_s.src = wdata[mtseq_pkg::CFG_SRC_LSB +: 2];
				next_s.zero = wdata[mtseq_pkg::CFG_ZERO_BIT];
				next_s.imp_auto = wdata[mtseq_pkg::CFG_IMP_BIT];
				next_s.dly_auto = wdata[mtseq_pkg::CFG_DLY_BIT];
				next_s.math = wdata[mtseq_pkg::CFG_MATH_BIT];
			end
			if (addr == mtseq_pkg::ADDR_COUNTS) begin
				next_s.samples = cnt_field(wdata, mtseq_pkg::CNT_SAMP_LSB);
				next_s.trigs = cnt_field(wdata, mtseq_pkg::CNT_TRIG_LSB);
			end
		end
		// interrupt status clear, write one
		if (wr && addr == mtseq_pkg::ADDR_IRQ_STAT) begin
			next_s.irq_stat = s.irq_stat & ~wdata[2:0];
		end
		if (wr && addr == mtseq_pkg::ADDR_IRQ_MASK) begin
			next_s.irq_mask = wdata[2:0];
		end
		case (s.state)
			mtseq_pkg::MTSEQ_IDLE: begin
				if (cmd && (wdata[2:0] == mtseq_pkg::CMD_CONFIGURE ||
					wdata[2:0] == mtseq_pkg::CMD_MEASURE)) begin
					// presets; function and plc from command data
					next_s.func = wdata[mtseq_pkg::CFG_FUNC_LSB +: 4];
					next_s.plc = wdata[mtseq_pkg::CFG_PLC_LSB +: 3]; // R10
					next_s.bw = mtseq_pkg::BW_20HZ; // R1
					next_s.zero = zero_for(wdata[mtseq_pkg::CFG_PLC_LSB +: 3]); // R2
					next_s.imp_auto = 1'b0; // R3
					next_s.samples = mtseq_pkg::COUNT_ONE; // R4
					next_s.trigs = mtseq_pkg::COUNT_ONE; // R4
					next_s.dly_auto = 1'b1; // R5
					next_s.src = mtseq_pkg::SRC_IMMEDIATE; // R5
					next_s.math = 1'b0; // R5
				end
				// measure arms at once; configure stays idle
				if (cmd && (wdata[2:0] == mtseq_pkg::CMD_MEASURE ||
					wdata[2:0] == mtseq_pkg::CMD_READ)) begin // R6 R8 R11
					next_s.state = mtseq_pkg::MTSEQ_WAIT;
					next_s.to_mem = 1'b0;
					next_s.samp_left = wdata[2:0] == mtseq_pkg::CMD_MEASURE ?
						mtseq_pkg::COUNT_ONE : s.samples;
					next_s.trig_left = wdata[2:0] == mtseq_pkg::CMD_MEASURE ?
						mtseq_pkg::COUNT_ONE : s.trigs;
				end
				if (cmd && wdata[2:0] == mtseq_pkg::CMD_INITIATE) begin
					if (total > mtseq_pkg::MEM_DEPTH) begin
						next_s.irq_stat[mtseq_pkg::IRQ_MEMERR] = 1'b1; // R15 R19
					end else begin
						next_s.state = mtseq_pkg::MTSEQ_WAIT; // R13
						next_s.to_mem = 1'b1;
						next_s.wr_ptr = '0;
						next_s.rd_ptr = '0;
						next_s.samp_left = s.samples;
						next_s.trig_left = s.trigs;
					end
				end
				if (cmd && wdata[2:0] == mtseq_pkg::CMD_FETCH &&
					s.rd_ptr != s.wr_ptr) begin
					next_s.state = mtseq_pkg::MTSEQ_FETCH; // R14
				end
			end
			mtseq_pkg::MTSEQ_WAIT: begin
				// immediate, bus or external pulse trigger
				if (fire) begin // R17
					next_s.state = mtseq_pkg::MTSEQ_MEAS;
					next_s.samp_left = s.samples;
					next_s.pending = 1'b0;
				end
			end
			mtseq_pkg::MTSEQ_MEAS: begin
				// start a sample when storing, or when output has room
				if (!s.pending && (s.to_mem || out_free)) begin // R12
					next_s.meas_start = 1'b1;
					next_s.pending = 1'b1;
				end
				// set wins over a clear in the same cycle
				if (!s.to_mem && s.out_valid && !out_ready) begin // R12
					next_s.irq_stat[mtseq_pkg::IRQ_FULL] = 1'b1;
				end
				if (s.pending && meas_done) begin
					next_s.pending = 1'b0;
					if (s.to_mem) begin
						next_s.wr_ptr = s.wr_ptr + 1'b1; // R13
					end else begin
						next_s.out_valid = 1'b1; // R11
						next_s.out_data = meas_data;
					end
					if (s.samp_left == mtseq_pkg::COUNT_ONE) begin
						if (s.trig_left == mtseq_pkg::COUNT_ONE) begin
							next_s.state = mtseq_pkg::MTSEQ_IDLE;
							next_s.irq_stat[mtseq_pkg::IRQ_DONE] = 1'b1;
						end else begin
							next_s.state = mtseq_pkg::MTSEQ_WAIT;
							next_s.trig_left = s.trig_left - 1'b1;
						end
					end else begin
						next_s.samp_left = s.samp_left - 1'b1;
					end
				end
			end
			mtseq_pkg::MTSEQ_FETCH: begin
				// one memory read in flight, then hand to output
				if (s.fetch_rd) begin
					next_s.out_valid = 1'b1; // R14
					next_s.out_data = mem_q;
					next_s.rd_ptr = s.rd_ptr + 1'b1;
					if (s.rd_ptr + 1'b1 == s.wr_ptr) begin
						next_s.state = mtseq_pkg::MTSEQ_IDLE;
					end
				end else if (out_free && !s.out_valid) begin
					next_s.fetch_rd = 1'b1;
				end
			end
			default: next_s.state = mtseq_pkg::MTSEQ_IDLE;
		endcase
		// read data mux, one cycle later
		next_s.rdata = '0;
		if (rd) begin
			case (addr)
				mtseq_pkg::ADDR_CFG: next_s.rdata = {16'h0000, s.math,
					s.dly_auto, s.imp_auto, s.zero, s.src, s.bw, 1'b0,
					s.plc, s.func};
				mtseq_pkg::ADDR_COUNTS: next_s.rdata = {6'h00, s.trigs,
					6'h00, s.samples};
				mtseq_pkg::ADDR_STATUS: next_s.rdata = {28'h0,
					single_range(s.func), s.to_mem, s.state}; // R9
				mtseq_pkg::ADDR_IRQ_STAT: next_s.rdata = {29'h0, s.irq_stat};
				mtseq_pkg::ADDR_IRQ_MASK: next_s.rdata = {29'h0, s.irq_mask};
				mtseq_pkg::ADDR_OUTBUF: next_s.rdata = {7'h00, s.out_valid,
					s.out_data};
				mtseq_pkg::ADDR_STORED: next_s.rdata = {22'h0, s.wr_ptr};
				default: next_s.rdata = '0;
			endcase
		end
		next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
		next_s.busy = next_s.state != mtseq_pkg::MTSEQ_IDLE; // R16
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rdata = s.rdata;
	assign meas_start = s.meas_start;
	assign out_valid = s.out_valid;
	assign out_data = s.out_data;
	assign busy = s.busy; // R16
	assign irq = s.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_preset_bw;
		@(posedge mclk) disable iff (!rst_n)
		(wr && addr == mtseq_pkg::ADDR_CMD && !busy &&
		wdata[2:0] == mtseq_pkg::CMD_CONFIGURE) |=>
		s.bw == mtseq_pkg::BW_20HZ && !s.imp_auto && s.dly_auto && !s.math;
	endproperty
	a_preset_bw: assert property (p_preset_bw) // R1
		else $error("preset not applied");

	property p_zero;
		@(posedge mclk) disable iff (!rst_n)
		(wr && addr == mtseq_pkg::ADDR_CMD && !busy &&
		wdata[2:0] == mtseq_pkg::CMD_CONFIGURE) |=>
		s.zero == (s.plc >= mtseq_pkg::PLC_1);
	endproperty
	a_zero: assert property (p_zero) // R2
		else $error("autozero preset wrong");

	property p_counts;
		@(posedge mclk) disable iff (!rst_n)
		(wr && addr == mtseq_pkg::ADDR_CMD && !busy &&
		wdata[2:0] == mtseq_pkg::CMD_MEASURE) |=>
		s.samples == mtseq_pkg::COUNT_ONE && s.trigs == mtseq_pkg::COUNT_ONE
		&& s.state == mtseq_pkg::MTSEQ_WAIT;
	endproperty
	a_counts: assert property (p_counts) // R4
		else $error("measure did not preset and arm");

	property p_cfg_idle;
		@(posedge mclk) disable iff (!rst_n)
		(wr && addr == mtseq_pkg::ADDR_CMD && !busy &&
		wdata[2:0] == mtseq_pkg::CMD_CONFIGURE) |=> !busy;
	endproperty
	a_cfg_idle: assert property (p_cfg_idle) // R8
		else $error("configure started measuring");

	property p_full_halt;
		@(posedge mclk) disable iff (!rst_n)
		(out_valid && !out_ready && !s.to_mem) |=> !meas_start;
	endproperty
	a_full_halt: assert property (p_full_halt) // R12
		else $error("measured while output full");

	property p_memerr;
		@(posedge mclk) disable iff (!rst_n)
		(wr && addr == mtseq_pkg::ADDR_CMD && !busy &&
		wdata[2:0] == mtseq_pkg::CMD_INITIATE &&
		20'(s.samples) * 20'(s.trigs) > mtseq_pkg::MEM_DEPTH) |=>
		s.irq_stat[mtseq_pkg::IRQ_MEMERR] && !busy;
	endproperty
	a_memerr: assert property (p_memerr) // R15
		else $error("memory error not raised");

	property p_busy_lock;
		@(posedge mclk) disable iff (!rst_n)
		(busy && wr && addr == mtseq_pkg::ADDR_COUNTS) |=>
		$stable(s.samples);
	endproperty
	a_busy_lock: assert property (p_busy_lock) // R16
		else $error("setting changed while busy");

	property p_read_out;
		@(posedge mclk) disable iff (!rst_n)
		(s.state == mtseq_pkg::MTSEQ_MEAS && s.pending && meas_done &&
		!s.to_mem) |=> out_valid && out_data == $past(meas_data);
	endproperty
	a_read_out: assert property (p_read_out) // R11
		else $error("reading not sent to output");
endmodule

//--- mtseq_front.sv
`timescale 1ns/100ps
// behavioural front end: answers each sample request after a short or long delay
module mtseq_front #(
	parameter logic [23:0] RDG_BASE = 24'hc30000
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// sample request and speed choice
	input wire logic meas_start,
	input wire logic slow,
	// reading back to the sequencer
	output logic meas_done,
	output logic [mtseq_pkg::RDG_W-1:0] meas_data
);
	logic [3:0] wait_cnt;
	logic pending;
	logic [23:0] n_rdg;

	// one sample in flight; data scrambled outside the valid cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wait_cnt <= 4'h0;
			pending <= 1'b0;
			n_rdg <= 24'h000000;
			meas_done <= 1'b0;
			meas_data <= 24'h000000;
		end else begin
			meas_done <= 1'b0;
			meas_data <= ~meas_data;
			if (meas_start) begin
				pending <= 1'b1;
				wait_cnt <= slow ? 4'h6 : 4'h0;
			end else if (pending && wait_cnt == 4'h0) begin
				pending <= 1'b0;
				meas_done <= 1'b1;
				meas_data <= RDG_BASE + n_rdg;
				n_rdg <= n_rdg + 24'h000001;
			end else if (pending) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
		end
	end
endmodule

//--- tb_measurement_trigger_sequencer.sv
`timescale 1ns/100ps
module tb_measurement_trigger_sequencer;
	localparam logic [23:0] RDG_BASE = 24'hc30000;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ext_trig = 1'b0;
	logic out_ready = 1'b0;
	logic slow = 1'b0;
	logic [31:0] rdata;
	logic meas_start, meas_done, out_valid, busy, irq;
	logic [23:0] meas_data, out_data;
	logic [23:0] exp_n = 24'h000000;
	int n_errors = 0;
	int n_checks = 0;
	int n_starts = 0;
	int s0 = 0;

	mtseq_top mtseq_top_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ext_trig(ext_trig), .meas_start(meas_start),
		.meas_done(meas_done), .meas_data(meas_data),
		.out_valid(out_valid), .out_data(out_data),
		.out_ready(out_ready), .busy(busy), .irq(irq));
	mtseq_front #(.RDG_BASE(RDG_BASE)) mtseq_front_inst (.mclk(mclk),
		.rst_n(rst_n), .meas_start(meas_start), .slow(slow),
		.meas_done(meas_done), .meas_data(meas_data));

	// clock and sample request count
	initial forever #50 mclk = ~mclk;
	always @(negedge mclk) if (meas_start === 1'b1) n_starts++;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic test_done();
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// read, mask and compare in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata & m, exp);
	endtask

	// wait for a reading on the stream and compare it
	task automatic see();
		int i;
		i = 0;
		do begin
			@(posedge mclk);
			#1;
			i++;
		end while (out_valid !== 1'b1 && i < 300);
		chk({7'h00, out_valid, out_data}, {8'h01, RDG_BASE + exp_n});
	endtask

	task automatic give();
		@(posedge mclk);
		out_ready <= 1'b1;
		@(posedge mclk);
		out_ready <= 1'b0;
		exp_n = exp_n + 24'h000001;
	endtask

	task automatic wait_idle(input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge mclk);
			#1;
			if (busy === 1'b0)
				return;
		end
		chk({31'h0, busy}, 32'h0);
	endtask

	task automatic pulse();
		@(posedge mclk);
		ext_trig <= 1'b1;
		@(posedge mclk);
		ext_trig <= 1'b0;
		repeat (20) @(posedge mclk);
	endtask

	// watchdog
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		test_done();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		rd_chk(mtseq_pkg::ADDR_STATUS, 32'hffffffff, 32'h0);
		rd_chk(4'hf, 32'hffffffff, 32'h0);
		// frequency and period report the single fixed range
		wr_reg(mtseq_pkg::ADDR_CFG, {28'h0, mtseq_pkg::FN_FREQUENCY});
		rd_chk(mtseq_pkg::ADDR_STATUS, 32'h8, 32'h8);
		wr_reg(mtseq_pkg::ADDR_CFG, {28'h0, mtseq_pkg::FN_PERIOD});
		rd_chk(mtseq_pkg::ADDR_STATUS, 32'h8, 32'h8);
		// configure presets for every integration setting
		for (int p = 0; p < 5; p++) begin
			wr_reg(mtseq_pkg::ADDR_CMD, 32'h1 | (p << 4));
			rd_chk(mtseq_pkg::ADDR_CFG, 32'hfff0,
				32'h4100 | ((p >= 2) << 12) | (p << 4));
			rd_chk(mtseq_pkg::ADDR_COUNTS, 32'hffffffff, 32'h10001);
			rd_chk(mtseq_pkg::ADDR_STATUS, 32'hf, 32'h0);
		end
		// read mode, done interrupt raised and cleared
		wr_reg(mtseq_pkg::ADDR_IRQ_MASK, 32'h7);
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h3);
		see();
		give();
		rd_chk(mtseq_pkg::ADDR_STORED, 32'h3ff, 32'h0);
		wait_idle(50);
		chk({31'h0, irq}, 32'h1);
		rd_chk(mtseq_pkg::ADDR_IRQ_STAT, 32'h7, 32'h1);
		wr_reg(mtseq_pkg::ADDR_IRQ_STAT, 32'h1);
		rd_chk(mtseq_pkg::ADDR_IRQ_STAT, 32'h7, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// full output stalls sampling; done masked off
		wr_reg(mtseq_pkg::ADDR_IRQ_MASK, 32'h2);
		wr_reg(mtseq_pkg::ADDR_COUNTS, 32'h00010002);
		slow <= 1'b1;
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h3);
		see();
		s0 = n_starts;
		repeat (30) @(posedge mclk);
		chk(n_starts - s0, 32'h0);
		rd_chk(mtseq_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
		give();
		see();
		give();
		wait_idle(50);
		chk({31'h0, irq}, 32'h0);
		wr_reg(mtseq_pkg::ADDR_IRQ_STAT, 32'h7);
		// external trigger into the store, then fetch
		wr_reg(mtseq_pkg::ADDR_CFG, 32'h4900);
		wr_reg(mtseq_pkg::ADDR_COUNTS, 32'h00030001);
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h4);
		rd_chk(mtseq_pkg::ADDR_STATUS, 32'h7, 32'h5);
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h1);
		wr_reg(mtseq_pkg::ADDR_COUNTS, 32'h00050005);
		rd_chk(mtseq_pkg::ADDR_COUNTS, 32'h03ff03ff, 32'h00030001);
		repeat (3) pulse();
		wait_idle(50);
		chk({31'h0, out_valid}, 32'h0);
		rd_chk(mtseq_pkg::ADDR_STORED, 32'h3ff, 32'h3);
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h5);
		repeat (3) begin
			see();
			give();
		end
		// bus trigger is the only command taken while armed
		wr_reg(mtseq_pkg::ADDR_CFG, 32'h4500);
		wr_reg(mtseq_pkg::ADDR_COUNTS, 32'h00010001);
		s0 = n_starts;
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h4);
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h3);
		repeat (10) @(posedge mclk);
		chk(n_starts - s0, 32'h0);
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h6);
		wait_idle(50);
		rd_chk(mtseq_pkg::ADDR_STORED, 32'h3ff, 32'h1);
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h5);
		see();
		give();
		// fetch with nothing stored stays idle
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h5);
		rd_chk(mtseq_pkg::ADDR_STATUS, 32'h3, 32'h0);
		// measure: presets, settings locked, reading at once
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h12);
		wr_reg(mtseq_pkg::ADDR_CFG, 32'h4900);
		see();
		give();
		rd_chk(mtseq_pkg::ADDR_CFG, 32'hfff0, 32'h4110);
		// exactly 512 readings is allowed
		slow <= 1'b0;
		wr_reg(mtseq_pkg::ADDR_COUNTS, 32'h00010200);
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h4);
		wait_idle(20000);
		rd_chk(mtseq_pkg::ADDR_STORED, 32'h3ff, 32'h200);
		rd_chk(mtseq_pkg::ADDR_IRQ_STAT, 32'h2, 32'h0);
		exp_n = exp_n + 24'h000200;
		// 17 x 32 readings overflows the store
		wr_reg(mtseq_pkg::ADDR_COUNTS, 32'h00110020);
		s0 = n_starts;
		wr_reg(mtseq_pkg::ADDR_CMD, 32'h4);
		rd_chk(mtseq_pkg::ADDR_STATUS, 32'h3, 32'h0);
		rd_chk(mtseq_pkg::ADDR_IRQ_STAT, 32'h2, 32'h2);
		chk(n_starts - s0, 32'h0);
		chk({31'h0, irq}, 32'h1);
		test_done();
	end
endmodule
